// >>> design/pmif_flags.sv
`timescale 1ns/1ns
module pmif_flags
  import pmif_pkg::*;
#(
  parameter int SC_HOLD_CYCLES = pmif_pkg::SC_CYCLES
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RESETN,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  input  wire logic        POWER_GOOD_PIN,
  input  wire logic        EXT_CLOCK_VALID,
  input  wire logic        THERMAL_SHUTDOWN_LIVE,
  input  wire logic        THERMAL_WARNING_LIVE,
  input  wire logic        OVERVOLTAGE_LIVE,
  input  wire logic        MEASUREMENT_DONE,
  input  wire logic        ANALOG_SUPPLY_LOW,
  input  wire logic        SOFTWARE_RESET_REQUEST,
  input  wire logic [1:0]  BUCK_PG_EVENT,
  input  wire logic [1:0]  BUCK_BELOW_SC,
  input  wire logic [1:0]  BUCK_ILIM_ACTIVE,
  input  wire logic [1:0]  LDO_PG_EVENT,
  input  wire logic [1:0]  LDO_BELOW_SC,
  input  wire logic [1:0]  LDO_ILIM_ACTIVE,
  input  wire logic [7:0]  MASK_TOP1,
  input  wire logic [7:0]  MASK_TOP2,
  input  wire logic [7:0]  MASK_BUCK,
  input  wire logic [7:0]  MASK_LDO,
  input  wire logic [3:0]  REG_EN_REQ,
  input  wire logic        GENERAL_OUTPUT_A_REQ,
  input  wire logic        GENERAL_OUTPUT_B_REQ,
  output logic      [3:0]  REG_EN,
  output logic             GENERAL_OUTPUT_A,
  output logic             GENERAL_OUTPUT_B,
  output logic             RESTORE_DEFAULTS,
  output logic             IRQ
);

  import pmif_pkg::*;

  localparam logic [SC_CNT_W-1:0] SC_LIMIT = SC_CNT_W'(SC_HOLD_CYCLES);

  // ==========================================================
  // flag storage
  logic [7:0] top1_r;
  logic [7:0] top2_r;
  logic [7:0] buck_r;
  logic [7:0] ldo_r;
  logic [7:0] top1_nxt;
  logic [7:0] top2_nxt;
  logic [7:0] buck_nxt;
  logic [7:0] ldo_nxt;
  logic [7:0] top1_set;
  logic [7:0] top2_set;
  logic [7:0] buck_set;
  logic [7:0] ldo_set;
  logic [7:0] top1_clr;
  logic [7:0] top2_clr;
  logic [7:0] buck_clr;
  logic [7:0] ldo_clr;
  logic [7:0] top1_view;

  logic       pgood_prev_r;
  logic       clk_valid_prev_r;
  logic       primed_r;
  logic       restart_evt;
  logic [3:0] sc_held;
  logic       irq_nxt;
  logic       shut_nxt;

  // ==========================================================
  // short-circuit hold timers: buck 0..1, linear 2..3
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sc
      pmif_hold_timer #(
        .CNT_W (SC_CNT_W),
        .LIMIT (SC_LIMIT)
      ) u_timer (
        .clk   (CLK_SYS),
        .rst_n (RESETN),
        .level ((gi < 2) ? BUCK_BELOW_SC[gi % 2] : LDO_BELOW_SC[gi % 2]),
        .held  (sc_held[gi])
      );
    end
  endgenerate

  // ==========================================================
  // edge detection on pin levels
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      pgood_prev_r <= 1'b0;
    end else begin
      pgood_prev_r <= POWER_GOOD_PIN;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      clk_valid_prev_r <= 1'b0;
    end else begin
      clk_valid_prev_r <= EXT_CLOCK_VALID;
    end
  end

  // first edge after reset sees reset values, not pin history
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      primed_r <= 1'b0;
    end else begin
      primed_r <= 1'b1;
    end
  end

  assign restart_evt = ANALOG_SUPPLY_LOW | SOFTWARE_RESET_REQUEST;

  // ==========================================================
  // event vectors
  always_comb begin
    top1_set = 8'h00;
    top1_set[TOP1_PGOOD_BIT] = primed_r && pgood_prev_r && !POWER_GOOD_PIN;
    top1_set[TOP1_SYNC_BIT]  = primed_r && (clk_valid_prev_r != EXT_CLOCK_VALID);
    top1_set[TOP1_TSD_BIT]   = THERMAL_SHUTDOWN_LIVE;
    top1_set[TOP1_TWARN_BIT] = THERMAL_WARNING_LIVE;
    top1_set[TOP1_OVP_BIT]   = OVERVOLTAGE_LIVE;
    top1_set[TOP1_MEAS_BIT]  = MEASUREMENT_DONE;
    top2_set = 8'h00;
    top2_set[TOP2_RESTART_BIT] = restart_evt;
    buck_set = chan_pack(BUCK_PG_EVENT, sc_held[1:0], BUCK_ILIM_ACTIVE);
    ldo_set  = chan_pack(LDO_PG_EVENT, sc_held[3:2], LDO_ILIM_ACTIVE);
  end

  // ==========================================================
  // write-1-to-clear decode
  always_comb begin
    top1_clr = 8'h00;
    top2_clr = 8'h00;
    buck_clr = 8'h00;
    ldo_clr  = 8'h00;
    if (REG_WR && REG_ADDR == ADDR_TOP1) begin
      top1_clr = REG_WDATA & TOP1_W1C_MASK;
    end else if (REG_WR && REG_ADDR == ADDR_TOP2) begin
      top2_clr = REG_WDATA & TOP2_W1C_MASK;
    end else if (REG_WR && REG_ADDR == ADDR_BUCK) begin
      buck_clr = REG_WDATA & CHAN_W1C_MASK;
    end else if (REG_WR && REG_ADDR == ADDR_LDO) begin
      ldo_clr  = REG_WDATA & CHAN_W1C_MASK;
    end
  end

  // ==========================================================
  // next flag values; restart returns the others to defaults
  always_comb begin
    top2_nxt = w1c_next(top2_r, top2_set, top2_clr);
    if (restart_evt) begin
      top1_nxt = FLAGS_RESET;
      buck_nxt = FLAGS_RESET;
      ldo_nxt  = FLAGS_RESET;
    end else begin
      top1_nxt = w1c_next(top1_r, top1_set, top1_clr) & TOP1_W1C_MASK;
      buck_nxt = w1c_next(buck_r, buck_set, buck_clr) & CHAN_W1C_MASK;
      ldo_nxt  = w1c_next(ldo_r, ldo_set, ldo_clr) & CHAN_W1C_MASK;
    end
  end

  // ==========================================================
  // flag registers, one per addressable register
  // set beats clear: an event in a clearing cycle keeps its flag
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      top1_r <= FLAGS_RESET;
    end else begin
      top1_r <= top1_nxt;
    end
  end

  // restart flag survives the restart it records
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      top2_r <= FLAGS_RESET;
    end else begin
      top2_r <= top2_nxt;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      buck_r <= FLAGS_RESET;
    end else begin
      buck_r <= buck_nxt;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ldo_r <= FLAGS_RESET;
    end else begin
      ldo_r <= ldo_nxt;
    end
  end

  // ==========================================================
  // first top register as read, with live summaries
  // summary bits are never stored in top1_r
  always_comb begin
    top1_view = top1_r;
    top1_view[TOP1_LDO_BIT]  = |ldo_r;
    top1_view[TOP1_BUCK_BIT] = |buck_r;
  end

  // ==========================================================
  // register read port
  // a read in a clearing cycle returns the value before the clear
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      REG_RDATA <= READ_UNMAPPED;
    end else if (REG_RD) begin
      if (REG_ADDR == ADDR_TOP1) begin
        REG_RDATA <= top1_view;
      end else if (REG_ADDR == ADDR_TOP2) begin
        REG_RDATA <= top2_r;
      end else if (REG_ADDR == ADDR_BUCK) begin
        REG_RDATA <= buck_r;
      end else if (REG_ADDR == ADDR_LDO) begin
        REG_RDATA <= ldo_r;
      end else begin
        REG_RDATA <= READ_UNMAPPED;
      end
    end
  end

  // ==========================================================
  // interrupt output tracks the next flag state
  // summaries stay out, their source flags are in
  always_comb begin
    irq_nxt = |(top1_nxt & ~MASK_TOP1) | |(top2_nxt & ~MASK_TOP2)
            | |(buck_nxt & ~MASK_BUCK) | |(ldo_nxt & ~MASK_LDO);
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= irq_nxt;
    end
  end

  // ==========================================================
  // regulator and general output gating
  // latched shutdown or overvoltage keeps outputs off until cleared
  assign shut_nxt = top1_nxt[TOP1_TSD_BIT] || top1_nxt[TOP1_OVP_BIT];

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      REG_EN <= REG_EN_OFF;
    end else if (shut_nxt || restart_evt) begin
      REG_EN <= REG_EN_OFF;
    end else begin
      REG_EN <= REG_EN_REQ;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      GENERAL_OUTPUT_A <= 1'b0;
      GENERAL_OUTPUT_B <= 1'b0;
    end else if (shut_nxt) begin
      GENERAL_OUTPUT_A <= 1'b0;
      GENERAL_OUTPUT_B <= 1'b0;
    end else begin
      GENERAL_OUTPUT_A <= GENERAL_OUTPUT_A_REQ;
      GENERAL_OUTPUT_B <= GENERAL_OUTPUT_B_REQ;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      RESTORE_DEFAULTS <= 1'b0;
    end else begin
      RESTORE_DEFAULTS <= restart_evt;
    end
  end

endmodule

// >>> design/pmif_hold_timer.sv
`timescale 1ns/1ns
module pmif_hold_timer #(
  parameter int                 CNT_W = 16,
  parameter logic [CNT_W-1:0]   LIMIT = 16'h61A8
) (
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  level,
  output logic       held
);

  logic [CNT_W-1:0] cnt_r;

  // ==========================================================
  // counts consecutive high cycles, saturating at the limit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (!level) begin
      cnt_r <= '0;
    end else if (cnt_r != LIMIT) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // high once level has stayed up for more than the limit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held <= 1'b0;
    end else begin
      held <= level && (cnt_r == LIMIT);
    end
  end

endmodule

// >>> design/pmif_pkg.sv
package pmif_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_TOP1 = 8'h19;
  localparam logic [7:0] ADDR_TOP2 = 8'h1A;
  localparam logic [7:0] ADDR_BUCK = 8'h1B;
  localparam logic [7:0] ADDR_LDO  = 8'h1C;

  // ==========================================================
  // first top register bit positions
  localparam int TOP1_PGOOD_BIT = 7;
  localparam int TOP1_LDO_BIT   = 6;
  localparam int TOP1_BUCK_BIT  = 5;
  localparam int TOP1_SYNC_BIT  = 4;
  localparam int TOP1_TSD_BIT   = 3;
  localparam int TOP1_TWARN_BIT = 2;
  localparam int TOP1_OVP_BIT   = 1;
  localparam int TOP1_MEAS_BIT  = 0;

  // second top register
  localparam int TOP2_RESTART_BIT = 0;

  // per-regulator register (buck and linear share the layout)
  localparam int CH1_PG_BIT   = 6;
  localparam int CH1_SC_BIT   = 5;
  localparam int CH1_ILIM_BIT = 4;
  localparam int CH0_PG_BIT   = 2;
  localparam int CH0_SC_BIT   = 1;
  localparam int CH0_ILIM_BIT = 0;

  // ==========================================================
  // reset values and writable masks
  localparam logic [7:0] FLAGS_RESET    = 8'h00;
  localparam logic [7:0] TOP1_W1C_MASK  = 8'h9F;
  localparam logic [7:0] TOP2_W1C_MASK  = 8'h01;
  localparam logic [7:0] CHAN_W1C_MASK  = 8'h77;
  localparam logic [7:0] READ_UNMAPPED  = 8'h00;
  localparam logic [3:0] REG_EN_OFF     = 4'h0;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SC_TIME_NS    = 1000000;
  localparam int SC_CYCLES     = (SC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SC_CNT_W      = 16;

  // ==========================================================
  // sticky update: set beats clear
  function automatic logic [7:0] w1c_next(input logic [7:0] flags,
                                          input logic [7:0] set,
                                          input logic [7:0] clr);
    return (flags & ~clr) | set;
  endfunction

  // pack one regulator pair into the shared layout
  function automatic logic [7:0] chan_pack(input logic [1:0] pg,
                                           input logic [1:0] sc,
                                           input logic [1:0] ilim);
    logic [7:0] v;
    v = 8'h00;
    v[CH1_PG_BIT]   = pg[1];
    v[CH1_SC_BIT]   = sc[1];
    v[CH1_ILIM_BIT] = ilim[1];
    v[CH0_PG_BIT]   = pg[0];
    v[CH0_SC_BIT]   = sc[0];
    v[CH0_ILIM_BIT] = ilim[0];
    return v;
  endfunction

endpackage

// >>> testbench/pmif_flags_assertions.sv
`timescale 1ns/1ns
module pmif_flags_assertions (
  input wire logic       CLK_SYS,
  input wire logic       RESETN,
  input wire logic [7:0] REG_ADDR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic       POWER_GOOD_PIN,
  input wire logic       THERMAL_SHUTDOWN_LIVE,
  input wire logic       OVERVOLTAGE_LIVE,
  input wire logic       MEASUREMENT_DONE,
  input wire logic       ANALOG_SUPPLY_LOW,
  input wire logic       SOFTWARE_RESET_REQUEST,
  input wire logic [7:0] MASK_TOP1,
  input wire logic [7:0] MASK_TOP2,
  input wire logic [7:0] MASK_BUCK,
  input wire logic [7:0] MASK_LDO,
  input wire logic [3:0] REG_EN,
  input wire logic       GENERAL_OUTPUT_A,
  input wire logic       GENERAL_OUTPUT_B,
  input wire logic       RESTORE_DEFAULTS,
  input wire logic       IRQ
);
  import pmif_pkg::*;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  wire no_rst = !SOFTWARE_RESET_REQUEST && !ANALOG_SUPPLY_LOW;
  wire off_all = REG_EN == 4'h0 && !GENERAL_OUTPUT_A && !GENERAL_OUTPUT_B;
  sequence s_restart;
    RESTORE_DEFAULTS && REG_EN == 4'h0;
  endsequence
  sequence s_shut;
    off_all;
  endsequence
  // ==========================================================
  // flags to irq
  AST_MEAS_IRQ: assert property (MEASUREMENT_DONE && !MASK_TOP1[0] && no_rst |=> IRQ)
    else $error("irq missing after measurement done");
  AST_PG_DROP: assert property ($fell(POWER_GOOD_PIN) && $past(RESETN) && !MASK_TOP1[7]
    && no_rst |=> IRQ)
    else $error("irq missing after power good drop");
  AST_ALL_MASKED: assert property (&MASK_TOP1 && MASK_TOP2[0] && &MASK_BUCK && &MASK_LDO |=> !IRQ)
    else $error("irq raised with all masked");
  // ==========================================================
  // shutdown paths
  AST_TSD_OFF: assert property (THERMAL_SHUTDOWN_LIVE && no_rst |=> s_shut)
    else $error("outputs not off after thermal shutdown");
  AST_OVP_OFF: assert property (OVERVOLTAGE_LIVE && no_rst |=> s_shut)
    else $error("outputs not off after overvoltage");
  AST_RESTART: assert property (!no_rst |=> s_restart)
    else $error("restart did not disable and restore");
  // ==========================================================
  // read port
  AST_RD_UNMAP: assert property (REG_RD && (REG_ADDR < ADDR_TOP1 || REG_ADDR > ADDR_LDO)
    |=> REG_RDATA == READ_UNMAPPED)
    else $error("unmapped read not zero");
  AST_RD_RSVD: assert property (REG_RD && REG_ADDR == ADDR_TOP2 |=> REG_RDATA[7:1] == 7'h00)
    else $error("reserved bits of restart register not zero");
  AST_RD_HOLD: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data changed without read");
endmodule

// >>> testbench/pmif_flags_tb.sv
`timescale 1ns/1ns
module pmif_flags_tb;
  import pmif_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, rd_seen = 1'b0;
  logic [7:0] addr, wdata, rdata, d, m1 = 0, m2 = 0, mb = 0, ml = 0;
  logic wr, rd, pg = 1'b1, eck = 0, tsd = 0, twn = 0, ovp = 0, meas = 0, asl = 0, swr = 0;
  logic [1:0] bpg = 0, bsc = 0, bil = 0, lpg = 0, lsc = 0, lil = 0;
  logic [3:0] en_req = 0, en;
  logic ga_req = 0, gb_req = 0, ga, gb, rdef, irq;
  logic [15:0] exp_q[$];
  logic [15:0] ent;
  int error_cnt = 0, n_tests = 0, seed = 45750;
  int bits[6] = '{0, 1, 2, 3, 4, 7};
  int sc_len[2] = '{8, 12};
  logic [7:0] sc_exp[2] = '{8'h00, 8'h22};
  always #20 clk = ~clk;
  pmif_flags #(.SC_HOLD_CYCLES(8)) u_dut (.CLK_SYS(clk), .RESETN(rstn), .REG_ADDR(addr),
    .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata), .POWER_GOOD_PIN(pg),
    .EXT_CLOCK_VALID(eck), .THERMAL_SHUTDOWN_LIVE(tsd), .THERMAL_WARNING_LIVE(twn),
    .OVERVOLTAGE_LIVE(ovp), .MEASUREMENT_DONE(meas), .ANALOG_SUPPLY_LOW(asl),
    .SOFTWARE_RESET_REQUEST(swr), .BUCK_PG_EVENT(bpg), .BUCK_BELOW_SC(bsc),
    .BUCK_ILIM_ACTIVE(bil), .LDO_PG_EVENT(lpg), .LDO_BELOW_SC(lsc), .LDO_ILIM_ACTIVE(lil),
    .MASK_TOP1(m1), .MASK_TOP2(m2), .MASK_BUCK(mb), .MASK_LDO(ml), .REG_EN_REQ(en_req),
    .GENERAL_OUTPUT_A_REQ(ga_req), .GENERAL_OUTPUT_B_REQ(gb_req), .REG_EN(en),
    .GENERAL_OUTPUT_A(ga), .GENERAL_OUTPUT_B(gb), .RESTORE_DEFAULTS(rdef), .IRQ(irq));
  pmif_host u_host (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd));
  // ==========================================================
  // read monitor
  always @(posedge clk) begin
    if (rd_seen && exp_q.size() > 0) begin
      ent = exp_q.pop_front();
      n_tests++;
      if (rdata !== ent[7:0]) begin
        error_cnt++;
        $display("MISMATCH rdata@%h exp %h got %h", ent[15:8], ent[7:0], rdata);
      end
    end
    rd_seen <= rd;
  end
  always @(posedge clk) begin
    if (rstn) begin
      {ga_req, gb_req, en_req} <= 6'($random(seed));
    end
  end
  task automatic rx(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({a, e});
    u_host.rd(a);
  endtask
  task automatic ev(input int b, input logic v);
    case (b)
      0: meas <= v;
      1: ovp <= v;
      2: twn <= v;
      3: tsd <= v;
      4: eck <= v;
      default: pg <= !v;
    endcase
  endtask
  task automatic stop_test();
    if (exp_q.size() != 0) begin
      error_cnt++;
      $display("MISMATCH pending_reads exp 0 got %0d", exp_q.size());
    end
    if (error_cnt == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end
  // ==========================================================
  // scenarios
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    foreach (bits[i]) rx(ADDR_TOP1 + 8'(i), 8'h00);
    rx(8'h1D, READ_UNMAPPED);
    foreach (bits[i]) begin
      @(posedge clk);
      ev(bits[i], 1'b1);
      @(posedge clk);
      ev(bits[i], 1'b0);
      rx(ADDR_TOP1, 8'h01 << bits[i]);
      @(negedge clk);
      if ((bits[i] == 1 || bits[i] == 3) && {en, ga, gb} !== 6'h00) begin
        error_cnt++;
        $display("MISMATCH outputs_off exp 00 got %h", {en, ga, gb});
      end
      u_host.wr(ADDR_TOP1, ~(8'h01 << bits[i]));
      rx(ADDR_TOP1, 8'h01 << bits[i]);
      u_host.wr(ADDR_TOP1, 8'hFF);
      rx(ADDR_TOP1, 8'h00);
    end
    {bpg, bil, lpg, lil} <= 8'hFF;
    @(posedge clk);
    {bpg, bil, lpg, lil} <= 8'h00;
    rx(ADDR_BUCK, 8'h55);
    rx(ADDR_LDO, 8'h55);
    u_host.wr(ADDR_TOP1, 8'hFF);
    rx(ADDR_TOP1, 8'h60);
    d = 8'($random(seed));
    u_host.wr(ADDR_BUCK, d);
    rx(ADDR_BUCK, 8'h55 & ~d);
    u_host.wr(ADDR_BUCK, 8'hFF);
    rx(ADDR_TOP1, 8'h40);
    u_host.wr(ADDR_LDO, 8'hFF);
    rx(ADDR_TOP1, 8'h00);
    foreach (sc_len[i]) begin
      {bsc, lsc} <= 4'hF;
      repeat (sc_len[i]) @(posedge clk);
      {bsc, lsc} <= 4'h0;
      rx(ADDR_BUCK, sc_exp[i]);
      rx(ADDR_LDO, sc_exp[i]);
    end
    u_host.wr(ADDR_BUCK, 8'hFF);
    u_host.wr(ADDR_LDO, 8'hFF);
    for (int s = 0; s < 2; s++) begin
      bil <= 2'b01;
      u_host.wr(ADDR_BUCK, 8'h01);
      rx(ADDR_BUCK, 8'h01);
      bil <= 2'b00;
      swr <= (s == 0);
      asl <= (s == 1);
      @(posedge clk);
      {swr, asl} <= 2'b00;
      rx(ADDR_BUCK, 8'h00);
      rx(ADDR_TOP2, 8'h01);
      u_host.wr(ADDR_TOP2, 8'hFF);
      rx(ADDR_TOP2, 8'h00);
    end
    {m1, m2, mb, ml} <= 32'hFFFFFFFF;
    ev(0, 1'b1);
    @(posedge clk);
    ev(0, 1'b0);
    rx(ADDR_TOP1, 8'h01);
    {m1, m2, mb, ml} <= 32'h00000000;
    @(posedge clk);
    @(negedge clk);
    if (irq !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH irq exp 1 got %b", irq);
    end
    u_host.wr(ADDR_TOP1, 8'hFF);
    @(negedge clk);
    if (irq !== 1'b0) begin
      error_cnt++;
      $display("MISMATCH irq exp 0 got %b", irq);
    end
    repeat (3) @(posedge clk);
    stop_test();
  end
endmodule
bind pmif_flags pmif_flags_assertions u_chk (
  .CLK_SYS                (CLK_SYS),
  .RESETN                 (RESETN),
  .REG_ADDR               (REG_ADDR),
  .REG_RD                 (REG_RD),
  .REG_RDATA              (REG_RDATA),
  .POWER_GOOD_PIN         (POWER_GOOD_PIN),
  .THERMAL_SHUTDOWN_LIVE  (THERMAL_SHUTDOWN_LIVE),
  .OVERVOLTAGE_LIVE       (OVERVOLTAGE_LIVE),
  .MEASUREMENT_DONE       (MEASUREMENT_DONE),
  .ANALOG_SUPPLY_LOW      (ANALOG_SUPPLY_LOW),
  .SOFTWARE_RESET_REQUEST (SOFTWARE_RESET_REQUEST),
  .MASK_TOP1              (MASK_TOP1),
  .MASK_TOP2              (MASK_TOP2),
  .MASK_BUCK              (MASK_BUCK),
  .MASK_LDO               (MASK_LDO),
  .REG_EN                 (REG_EN),
  .GENERAL_OUTPUT_A       (GENERAL_OUTPUT_A),
  .GENERAL_OUTPUT_B       (GENERAL_OUTPUT_B),
  .RESTORE_DEFAULTS       (RESTORE_DEFAULTS),
  .IRQ                    (IRQ)
);

// >>> testbench/pmif_host.sv
`timescale 1ns/1ns
module pmif_host (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // idle lines show inverted value, never a stale copy
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
  endtask
endmodule
